// [rtl/sbs_pkg.sv]
package sbs_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int LANES   = 2;
  localparam int WORDS   = 1048576;
  localparam int BURST_W = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  // pins default to their internal pulls: order high, sleep low, enable off
  localparam logic       ORDER_RST  = 1'h1;
  localparam logic       SLEEP_RST  = 1'h0;
  localparam logic       OE_N_RST   = 1'h1;
  localparam logic [1:0] LANES_NONE = 2'h0;
  localparam logic [1:0] LANES_ALL  = 2'h3;
  localparam logic [1:0] CNT_RST    = 2'h0;
  localparam logic [1:0] CNT_STEP   = 2'h1;

endpackage

// [rtl/sbs_burst_step.sv]
`timescale 1ns/1ns
module sbs_burst_step (
  input  wire logic [1:0] base_lsb,
  input  wire logic [1:0] count,
  input  wire logic       interleave,
  output logic      [1:0] lsb
);

  // ----------------------------------------
  // burst order
  // ----------------------------------------
  // only the two low address bits ever move
  logic [1:0] lin_lsb;
  logic [1:0] xor_lsb;

  assign lin_lsb = 2'(base_lsb + count);
  assign xor_lsb = base_lsb ^ count;
  assign lsb     = interleave ? xor_lsb : lin_lsb;

endmodule

// [rtl/sbs_sram_core.sv]
// Contract
// - clocked inputs; enable, sleep, order are not
// - address captured only when selected and strobed
// - data driven only selected and enabled
// - master select blocks processor strobe only
// - secondary selects high and low active
// - processor strobe loads address or deselects
// - controller strobe loads address or deselects
// - advance low continues the burst
// - global write writes all 18 bits
// - lane writes need lane enable, global high
// - each low lane write writes its lane
// - no write decode means read cycle
// - output enable gates driving during reads
// - order select high interleaved, low linear
// - sleep deselects and keeps stored data
// - asleep ignores inputs, outputs high impedance
// - sleep defaults low, normal operation
// - read data out one edge after address
// - step only with advance, controller strobe high, processor strobe high or blocked
// - processor strobe start ignores lane writes
`timescale 1ns/1ns
module sbs_sram_core (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic [sbs_pkg::ADDR_W-1:0]  addr,
  input  wire logic                        master_select_n,
  input  wire logic                        select_high,
  input  wire logic                        select_low_n,
  input  wire logic                        proc_addr_strobe_n,
  input  wire logic                        ctrl_addr_strobe_n,
  input  wire logic                        burst_advance_n,
  input  wire logic                        write_all_n,
  input  wire logic                        lane_write_enable_n,
  input  wire logic [sbs_pkg::LANES-1:0]   lane_write_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        burst_order_sel_n,
  input  wire logic                        sleep_request,
  input  wire logic [sbs_pkg::DATA_W-1:0]  dq_in,
  output logic      [sbs_pkg::DATA_W-1:0]  dq_out,
  output logic                             dq_oe,
  output logic                             sleep_active
);

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [sbs_pkg::DATA_W-1:0] mem [sbs_pkg::WORDS];
  logic                       oe_meta_r;
  logic                       oe_sync_r;
  logic                       zz_meta_r;
  logic                       zz_sync_r;
  logic                       ord_meta_r;
  logic                       ord_sync_r;
  logic [sbs_pkg::ADDR_W-1:0] a_r;
  logic [sbs_pkg::ADDR_W-1:0] a_nxt;
  logic [1:0]                 base_lsb_r;
  logic [1:0]                 cnt_r;
  logic [1:0]                 cnt_nxt;
  logic                       active_r;
  logic                       rd_stage_r;
  logic                       dcd_r;
  logic [sbs_pkg::DATA_W-1:0] dout_r;
  logic                       dq_oe_r;
  logic                       dq_oe_nxt;
  logic                       sleep_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic                       asleep;
  logic                       sel_all;
  logic                       proc_go;
  logic                       ctrl_go;
  logic                       strobe_go;
  logic                       start_acc;
  logic                       deselect;
  logic                       cont;
  logic                       step;
  logic [1:0]                 lanes_req;
  logic [1:0]                 wr_lanes;
  logic                       wr_any;
  logic                       is_read;
  logic [1:0]                 step_lsb;
  logic                       out_live;

  function automatic logic [1:0] lane_mask(
    input logic       all_n,
    input logic       en_n,
    input logic [1:0] lane_n
  );
    logic [1:0] m;
    m = sbs_pkg::LANES_NONE;
    if (!all_n) begin
      m = sbs_pkg::LANES_ALL;
    end else if (!en_n) begin
      m = ~lane_n;
    end
    return m;
  endfunction

  assign asleep    = zz_sync_r;
  assign sel_all   = !master_select_n & select_high & !select_low_n;
  // a blocked processor strobe falls through to the controller strobe
  assign proc_go   = !proc_addr_strobe_n & !master_select_n;
  assign ctrl_go   = !ctrl_addr_strobe_n & !proc_go;
  assign strobe_go = (proc_go | ctrl_go) & !asleep;
  assign start_acc = strobe_go & sel_all;
  assign deselect  = strobe_go & !sel_all;
  assign cont      = ctrl_addr_strobe_n & !proc_go & active_r & !asleep;
  assign step      = cont & !burst_advance_n;
  assign lanes_req = lane_mask(write_all_n, lane_write_enable_n, lane_write_n);
  // processor strobe start is always a read; lanes count from the next edge
  assign wr_lanes  = ((start_acc & ctrl_go) | cont) ? lanes_req
                                                    : sbs_pkg::LANES_NONE;
  assign wr_any    = |wr_lanes;
  assign is_read   = (start_acc | cont) & !wr_any;
  assign out_live  = rd_stage_r | dcd_r;

  sbs_burst_step u_step (
    .base_lsb   (base_lsb_r),
    .count      (cnt_nxt),
    .interleave (ord_sync_r),
    .lsb        (step_lsb)
  );

  assign cnt_nxt = 2'(cnt_r + sbs_pkg::CNT_STEP);
  assign a_nxt   = start_acc ? addr
                 : {a_r[sbs_pkg::ADDR_W-1:2], (step ? step_lsb : a_r[1:0])};

  // output drivers drop on a write edge so a write never fights read data
  assign dq_oe_nxt = !oe_sync_r & !asleep & out_live & !wr_any;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // enable and sleep arrive unclocked; two stages cost latency, not safety
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oe_meta_r  <= sbs_pkg::OE_N_RST;
      oe_sync_r  <= sbs_pkg::OE_N_RST;
      zz_meta_r  <= sbs_pkg::SLEEP_RST;
      zz_sync_r  <= sbs_pkg::SLEEP_RST;
      ord_meta_r <= sbs_pkg::ORDER_RST;
      ord_sync_r <= sbs_pkg::ORDER_RST;
    end else begin
      oe_meta_r  <= output_enable_n;
      oe_sync_r  <= oe_meta_r;
      zz_meta_r  <= sleep_request;
      zz_sync_r  <= zz_meta_r;
      ord_meta_r <= burst_order_sel_n;
      ord_sync_r <= ord_meta_r;
    end
  end

  // ----------------------------------------
  // address and burst
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      a_r        <= '0;
      base_lsb_r <= sbs_pkg::CNT_RST;
      cnt_r      <= sbs_pkg::CNT_RST;
    end else if (start_acc) begin
      a_r        <= a_nxt;
      base_lsb_r <= addr[1:0];
      cnt_r      <= sbs_pkg::CNT_RST;
    end else if (step) begin
      a_r        <= a_nxt;
      cnt_r      <= cnt_nxt;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      active_r <= 1'h0;
    end else if (asleep | deselect) begin
      active_r <= 1'h0;
    end else if (start_acc) begin
      active_r <= 1'h1;
    end
  end

  // ----------------------------------------
  // array
  // ----------------------------------------
  // no reset on the array: contents survive sleep
  always_ff @(posedge clock) begin
    for (int i = 0; i < sbs_pkg::LANES; i++) begin
      if (wr_lanes[i]) begin
        mem[a_nxt][i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] <=
          dq_in[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rd_stage_r) begin
      dout_r <= mem[a_r];
    end
  end

  // ----------------------------------------
  // output pipeline
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_stage_r <= 1'h0;
      dcd_r      <= 1'h0;
      dq_oe_r    <= 1'h0;
      sleep_r    <= sbs_pkg::SLEEP_RST;
    end else begin
      rd_stage_r <= is_read & !asleep;
      dcd_r      <= rd_stage_r & !is_read & !wr_any & !asleep;
      dq_oe_r    <= dq_oe_nxt;
      sleep_r    <= zz_sync_r;
    end
  end

  assign dq_out       = dout_r;
  assign dq_oe        = dq_oe_r;
  assign sleep_active = sleep_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_sleep_quiet;
    zz_sync_r |=> !dq_oe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("outputs driven while asleep");

  property p_read_pipe;
    rd_stage_r && !oe_sync_r && !zz_sync_r && !wr_any |=> dq_oe && dq_out == mem[$past(a_r)];
  endproperty
  a_read_pipe: assert property (p_read_pipe)
    else $error("read data not on pins one edge later");

  property p_addr_load;
    start_acc |=> a_r == $past(addr) && active_r;
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address not captured on selected strobe");

  property p_deselect;
    deselect |=> !active_r;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("strobe without selects did not deselect");

  property p_proc_blocked;
    !proc_addr_strobe_n && master_select_n && ctrl_addr_strobe_n && burst_advance_n
      |=> $stable(a_r);
  endproperty
  a_proc_blocked: assert property (p_proc_blocked)
    else $error("blocked processor strobe moved the address");

  property p_write_all;
    cont && !write_all_n |-> wr_lanes == sbs_pkg::LANES_ALL;
  endproperty
  a_write_all: assert property (p_write_all)
    else $error("global write missed a lane");

  property p_proc_read;
    start_acc && proc_go |-> !wr_any && is_read;
  endproperty
  a_proc_read: assert property (p_proc_read)
    else $error("processor strobe start wrote");

  property p_oe_off;
    output_enable_n [*3] |=> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("drive while enable high");

  property p_step_upper;
    step |=> a_r[sbs_pkg::ADDR_W-1:2] == $past(a_r[sbs_pkg::ADDR_W-1:2]);
  endproperty
  a_step_upper: assert property (p_step_upper)
    else $error("burst touched upper address bits");

  sequence s_read_then_idle;
    rd_stage_r && !is_read && !wr_any && !zz_sync_r && !oe_sync_r
      ##1 (!wr_any && !zz_sync_r && !oe_sync_r);
  endsequence
  property p_dcd;
    s_read_then_idle |=> dq_oe;
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("extra deselect clock not driven");

  // once the pipeline is empty nothing may hold the pins
  property p_dcd_end;
    !rd_stage_r && !dcd_r |=> !dq_oe;
  endproperty
  a_dcd_end: assert property (p_dcd_end)
    else $error("drive beyond the extra deselect clock");

  property p_ctrl_start;
    !ctrl_addr_strobe_n && proc_addr_strobe_n && !master_select_n && select_high
      && !select_low_n && !zz_sync_r |=> active_r && a_r == $past(addr);
  endproperty
  a_ctrl_start: assert property (p_ctrl_start)
    else $error("controller strobe did not start an access");

  property p_lane_gate;
    write_all_n && lane_write_enable_n |-> !wr_any;
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("lane write without lane enable");

  property p_lane_write;
    cont && write_all_n && !lane_write_enable_n |-> wr_lanes == ~lane_write_n;
  endproperty
  a_lane_write: assert property (p_lane_write)
    else $error("lane write reached the wrong lane");

  // a write edge must never leave the drivers on, whatever the enable says
  property p_wr_quiet;
    wr_any |=> !dq_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("pins driven after a write edge");

  property p_sleep_hold;
    zz_sync_r |=> !active_r && !rd_stage_r;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("access survived sleep");

  property p_sleep_flag;
    zz_sync_r |=> sleep_active;
  endproperty
  a_sleep_flag: assert property (p_sleep_flag)
    else $error("sleep not reported");

  c_burst_read: cover property (start_acc && is_read ##1 step [*3]);
  c_lane_write: cover property (cont && wr_lanes == 2'h1);
  c_sleep:      cover property (active_r ##1 zz_sync_r [*2]);
  c_dcd:        cover property (dcd_r && dq_oe);
  c_ctrl_write: cover property (start_acc && ctrl_go && wr_any);

endmodule

// [dv/sbs_bus_master.sv]
`timescale 1ns/1ns
module sbs_bus_master (
  input  wire logic                       clock,
  input  wire logic [sbs_pkg::DATA_W-1:0] dq_out,
  input  wire logic                       dq_oe,
  output logic      [sbs_pkg::ADDR_W-1:0] addr,
  output logic                            master_select_n,
  output logic                            select_high,
  output logic                            select_low_n,
  output logic                            proc_addr_strobe_n,
  output logic                            ctrl_addr_strobe_n,
  output logic                            burst_advance_n,
  output logic                            write_all_n,
  output logic                            lane_write_enable_n,
  output logic      [1:0]                 lane_write_n,
  output logic                            output_enable_n,
  output logic                            burst_order_sel_n,
  output logic                            sleep_request,
  output logic      [sbs_pkg::DATA_W-1:0] dq_in
);
  logic [sbs_pkg::DATA_W-1:0] wd, idle_r;
  logic [sbs_pkg::DATA_W-1:0] rd [0:3];
  logic                       oe [0:3];
  logic                       drv;
  // released bus toggles each cycle, so stale data never passes for write data
  assign dq_in = dq_oe ? dq_out : (drv ? wd : ~idle_r);
  always @(posedge clock) idle_r <= dq_in;
  initial begin
    {addr, wd, idle_r, drv} = '0;
    {master_select_n, select_high, select_low_n, proc_addr_strobe_n, ctrl_addr_strobe_n,
     burst_advance_n} = 6'h2F;
    {write_all_n, lane_write_enable_n, lane_write_n, output_enable_n, burst_order_sel_n,
     sleep_request} = 7'h7E;
  end
  task automatic start(input logic [sbs_pkg::ADDR_W-1:0] a, input logic [2:0] sel,
                       input logic proc);
    @(posedge clock);
    addr <= a;
    {master_select_n, select_high, select_low_n, proc_addr_strobe_n,
     ctrl_addr_strobe_n} <= {sel, ~proc, proc};
  endtask
  task automatic wr(input logic [sbs_pkg::ADDR_W-1:0] a, input logic [sbs_pkg::DATA_W-1:0] d,
                    input logic proc, gw, lwe, input logic [1:0] ln);
    @(posedge clock);
    output_enable_n <= 1'h1; // drivers off before write data
    repeat (3) @(posedge clock);
    start(a, 3'h2, proc);
    {write_all_n, lane_write_enable_n, lane_write_n} <= {gw, lwe, ln};
    {wd, drv} <= {d, 1'h1};
    @(posedge clock);
    {proc_addr_strobe_n, ctrl_addr_strobe_n} <= 2'h3;
    // lanes held for one suspend edge, dropped after a processor start
    if (proc) {write_all_n, lane_write_enable_n, lane_write_n} <= 4'hF;
    @(posedge clock); // suspend write repeats the same word
    {write_all_n, lane_write_enable_n, lane_write_n, drv} <= 5'h1E;
  endtask
  task automatic rd_burst(input logic [sbs_pkg::ADDR_W-1:0] a, input logic [2:0] sel,
                          input logic proc, input int n, input logic en);
    @(posedge clock);
    output_enable_n <= ~en;
    repeat (3) @(posedge clock);
    start(a, sel, proc);
    @(posedge clock);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= {2'h3, n < 2};
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      burst_advance_n <= (i + 2 >= n);
      #1;
      rd[i] = dq_out;
      oe[i] = dq_oe;
    end
  endtask
  task automatic statics(input logic ord, slp);
    @(posedge clock);
    {burst_order_sel_n, sleep_request} <= {ord, slp}; // only between accesses
    repeat (4) @(posedge clock);
    #1;
  endtask
endmodule

// [dv/sbs_sram_core_test.sv]
`timescale 1ns/1ns
module sbs_sram_core_test;
  localparam logic [sbs_pkg::ADDR_W-1:0] A = 20'h00040;
  localparam logic [sbs_pkg::ADDR_W-1:0] B = 20'h0ABFC;
  logic [sbs_pkg::ADDR_W-1:0] addr;
  logic [sbs_pkg::DATA_W-1:0] dq_in, dq_out;
  logic [1:0]                 lane_write_n;
  logic                       clock = 1'h0, nrst = 1'h0, dq_oe, sleep_active;
  logic                       master_select_n, select_high, select_low_n, burst_advance_n;
  logic                       proc_addr_strobe_n, ctrl_addr_strobe_n, write_all_n;
  logic                       lane_write_enable_n, output_enable_n;
  logic                       burst_order_sel_n, sleep_request;
  int                         mismatches = 0, checked = 0, cycles = 0;
  always #25 clock = ~clock;
  sbs_sram_core i_sbs_sram_core (.clock, .nrst, .addr, .master_select_n, .select_high,
    .select_low_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .write_all_n,
    .lane_write_enable_n, .lane_write_n, .output_enable_n, .burst_order_sel_n,
    .sleep_request, .dq_in, .dq_out, .dq_oe, .sleep_active);
  sbs_bus_master i_sbs_bus_master (.clock, .dq_out, .dq_oe, .addr, .master_select_n,
    .select_high, .select_low_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n,
    .write_all_n, .lane_write_enable_n, .lane_write_n, .output_enable_n,
    .burst_order_sel_n, .sleep_request, .dq_in);
  task automatic cmp_w(input logic [sbs_pkg::DATA_W-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic wr_chk(input logic proc, gw, lwe, input logic [1:0] ln,
                        input logic [sbs_pkg::DATA_W-1:0] d, exp);
    i_sbs_bus_master.wr(A, d, proc, gw, lwe, ln);
    i_sbs_bus_master.rd_burst(A, 3'h2, 1'h0, 1, 1'h1);
    cmp_w(i_sbs_bus_master.rd[0], exp);
    cmp_b(i_sbs_bus_master.oe[0], 1'h1);
  endtask
  task automatic t_writes;
    wr_chk(1'h0, 1'h0, 1'h1, 2'h3, 18'h3FFFF, 18'h3FFFF);
    wr_chk(1'h0, 1'h1, 1'h0, 2'h2, 18'h00000, 18'h3FE00);
    wr_chk(1'h0, 1'h1, 1'h0, 2'h1, 18'h00000, 18'h00000);
    wr_chk(1'h0, 1'h1, 1'h1, 2'h0, 18'h15555, 18'h00000);
    wr_chk(1'h0, 1'h1, 1'h0, 2'h3, 18'h15555, 18'h00000);
    wr_chk(1'h0, 1'h0, 1'h0, 2'h1, 18'h2ABCD, 18'h2ABCD);
    wr_chk(1'h0, 1'h1, 1'h0, 2'h0, 18'h12345, 18'h12345);
    wr_chk(1'h1, 1'h1, 1'h0, 2'h0, 18'h00000, 18'h12345);
    // blocked processor strobe: the suspended read of A keeps its data
    i_sbs_bus_master.rd_burst(A + 20'h00010, 3'h6, 1'h1, 1, 1'h1);
    cmp_w(i_sbs_bus_master.rd[0], 18'h12345);
  endtask
  task automatic t_deselect;
    logic [3:0] sel [0:3] = '{4'h6, 4'h0, 4'h3, 4'h8};
    for (int k = 0; k < 4; k++) begin
      i_sbs_bus_master.rd_burst(A, 3'h2, 1'h0, 1, 1'h1);
      i_sbs_bus_master.rd_burst(A, sel[k][2:0], sel[k][3], 2, 1'h1);
      cmp_b(i_sbs_bus_master.oe[0], 1'h1);
      cmp_b(i_sbs_bus_master.oe[1], 1'h0);
    end
    i_sbs_bus_master.rd_burst(A, 3'h2, 1'h0, 1, 1'h0);
    cmp_b(i_sbs_bus_master.oe[0], 1'h0);
  endtask
  task automatic t_burst;
    int e;
    for (int i = 0; i < 4; i++)
      i_sbs_bus_master.wr(B + 20'(i), 18'h00100 + 18'(i), 1'h0, 1'h0, 1'h1, 2'h3);
    for (int o = 0; o < 2; o++) begin
      i_sbs_bus_master.statics(1'(o), 1'h0);
      for (int s = 0; s < 4; s++) begin
        i_sbs_bus_master.rd_burst(B + 20'(s), 3'h2, 1'(s), 4, 1'h1);
        for (int i = 0; i < 4; i++) begin
          e = o ? s ^ i : (s + i) % 4;
          cmp_w(i_sbs_bus_master.rd[i], 18'h00100 + 18'(e));
        end
      end
    end
  endtask
  task automatic t_sleep;
    i_sbs_bus_master.wr(A, 18'h15A5A, 1'h0, 1'h0, 1'h1, 2'h3);
    i_sbs_bus_master.statics(1'h1, 1'h1);
    cmp_b(sleep_active, 1'h1);
    i_sbs_bus_master.rd_burst(A, 3'h2, 1'h0, 1, 1'h1);
    cmp_b(i_sbs_bus_master.oe[0], 1'h0);
    i_sbs_bus_master.wr(A, 18'h00000, 1'h0, 1'h0, 1'h1, 2'h3);
    i_sbs_bus_master.statics(1'h1, 1'h0);
    cmp_b(sleep_active, 1'h0);
    i_sbs_bus_master.rd_burst(A, 3'h2, 1'h0, 1, 1'h1); // only reads after waking
    cmp_w(i_sbs_bus_master.rd[0], 18'h15A5A);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'h1;
    t_writes();
    t_deselect();
    t_burst();
    t_sleep();
    end_of_test();
  end
endmodule
